// File: hw/sdram_cmd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdram_cmd_defs.svh"
module sdram_cmd_decoder #(
  parameter int DQ_W = 16,
  parameter int COL_W = 8,
  parameter int REF_INT_CYC = `SELF_REFRESH_INT_CYC
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Command pins
  input wire sdram_cmd_pkg::cmd_bus_t cmd_i,
  input wire logic data_mask_i,
  input wire logic [DQ_W-1:0] dq_i,
  // Read data to pins
  output logic [DQ_W-1:0] dq_o,
  output logic dq_oe_o,
  // Array side
  output sdram_cmd_pkg::array_req_t act_o,
  output sdram_cmd_pkg::array_req_t rd_o,
  output sdram_cmd_pkg::array_req_t wr_o,
  output logic [DQ_W-1:0] wr_data_o,
  input wire logic [DQ_W-1:0] rd_data_i,
  output logic [11:0] refresh_row_o,
  output logic refresh_o,
  // Status
  output logic [3:0] bank_open_o,
  output logic [11:0] mode_o,
  output logic self_refresh_o
);
  import sdram_cmd_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Input stage
  cmd_bus_t cmd_s1, cmd_reg;
  logic dm_s1, dm_reg;
  logic [DQ_W-1:0] dq_s1, dq_reg;
  always_ff @(posedge core_clk_i)
  begin
    cmd_s1 <= cmd_i;
    cmd_reg <= cmd_s1;
    dm_s1 <= data_mask_i;
    dm_reg <= dm_s1;
    dq_s1 <= dq_i;
    dq_reg <= dq_s1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Decode
  function automatic cmd_t decode(input cmd_bus_t c);
    cmd_t r;
    r = CMD_NOP;
    if (!c.chip_select_n)
    begin
      case ({c.row_strobe_n, c.column_strobe_n, c.write_enable_n})
        3'b011: r = CMD_ACT;
        3'b101: r = CMD_RD;
        3'b100: r = CMD_WR;
        3'b110: r = CMD_BST;
        3'b010: r = CMD_PRE;
        3'b001: r = c.clock_enable ? CMD_REF : CMD_SREF;
        3'b000: r = CMD_MRS;
        default: r = CMD_NOP;
      endcase
      if (!c.clock_enable && r != CMD_SREF)
        r = CMD_NOP;
    end
    return r;
  endfunction

  cmd_t cmd;
  logic [1:0] bank;
  logic [9:0] col;
  logic in_sref_reg;
  assign bank = {cmd_reg.bank_select_bit1, cmd_reg.bank_select_bit0};
  assign cmd = in_sref_reg ? CMD_NOP : decode(cmd_reg);
  assign col = 10'(cmd_reg.addr[COL_W-1:0]);

  ////////////////////////////////////////////////////////////////////////
  // Mode register
  logic [11:0] mode_reg;
  logic [2:0] mrd_cnt_reg;
  logic [3:0] open_reg;
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
      mode_reg <= `MODE_RESET;
    else if (cmd == CMD_MRS && open_reg == 4'h0)
      mode_reg <= cmd_reg.addr;
  end
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
      mrd_cnt_reg <= 3'h0;
    else if (cmd == CMD_MRS)
      mrd_cnt_reg <= 3'(`MODE_LOAD_WAIT_CYC);
    else if (mrd_cnt_reg != 3'h0)
      mrd_cnt_reg <= mrd_cnt_reg - 3'h1;
  end
  logic full_page;
  logic [8:0] burst_len;
  logic cl3;
  assign cl3 = mode_reg[`MODE_CL_LSB];
  assign full_page = mode_reg[`MODE_BL_LSB+2:`MODE_BL_LSB] == 3'h7;
  assign burst_len = 9'h1 << mode_reg[`MODE_BL_LSB+1:`MODE_BL_LSB];

  ////////////////////////////////////////////////////////////////////////
  // Bank state
  logic [11:0] row_reg [4];
  logic [3:0] pre_due;
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
      open_reg <= 4'h0;
    else
    begin
      if (cmd == CMD_ACT)
        open_reg[bank] <= 1'b1;
      else if (cmd == CMD_PRE)
      begin
        if (cmd_reg.addr[10])
          open_reg <= 4'h0;
        else
          open_reg[bank] <= 1'b0;
      end
      open_reg <= (cmd == CMD_ACT) ? (open_reg | (4'h1 << bank)) & ~pre_due :
        (cmd == CMD_PRE) ? (cmd_reg.addr[10] ? 4'h0 : open_reg & ~(4'h1 << bank) & ~pre_due) :
        open_reg & ~pre_due;
    end
  end
  always_ff @(posedge core_clk_i)
  begin
    if (cmd == CMD_ACT)
      row_reg[bank] <= cmd_reg.addr;
  end

  ////////////////////////////////////////////////////////////////////////
  // Burst engine
  logic burst_rd_reg, burst_wr_reg, ap_reg;
  logic [1:0] bbank_reg;
  logic [9:0] bcol_reg;
  logic [8:0] left_reg;
  logic last;
  assign last = (left_reg == 9'h1) && !full_page;
  assign pre_due = ((burst_rd_reg || burst_wr_reg) && last && ap_reg && cmd != CMD_RD && cmd != CMD_WR
    && cmd != CMD_BST) ? (4'h1 << bbank_reg) : 4'h0;
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      burst_rd_reg <= 1'b0;
      burst_wr_reg <= 1'b0;
      ap_reg <= 1'b0;
      left_reg <= 9'h0;
      bbank_reg <= 2'h0;
      bcol_reg <= 10'h0;
    end
    else if (cmd == CMD_RD || cmd == CMD_WR)
    begin
      burst_rd_reg <= cmd == CMD_RD;
      burst_wr_reg <= cmd == CMD_WR;
      ap_reg <= cmd_reg.addr[10];
      bbank_reg <= bank;
      bcol_reg <= col;
      left_reg <= (cmd == CMD_WR && mode_reg[`MODE_WB_BIT]) ? 9'h1 : burst_len;
    end
    else if (cmd == CMD_BST || cmd == CMD_PRE)
    begin
      burst_rd_reg <= 1'b0;
      burst_wr_reg <= 1'b0;
      ap_reg <= 1'b0;
    end
    else if (burst_rd_reg || burst_wr_reg)
    begin
      bcol_reg <= 10'(bcol_reg + 10'h1) & 10'((1 << COL_W) - 1);
      left_reg <= left_reg - 9'h1;
      if (last)
      begin
        burst_rd_reg <= 1'b0;
        burst_wr_reg <= 1'b0;
      end
    end
  end
  logic rd_beat, wr_beat;
  assign rd_beat = cmd == CMD_RD || (burst_rd_reg && !last && cmd != CMD_BST && cmd != CMD_WR);
  assign wr_beat = cmd == CMD_WR || (burst_wr_reg && !last && cmd != CMD_BST && cmd != CMD_RD);

  ////////////////////////////////////////////////////////////////////////
  // Array requests
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      act_o <= '0;
      rd_o <= '0;
      wr_o <= '0;
      wr_data_o <= '0;
    end
    else
    begin
      act_o <= '{cmd == CMD_ACT, bank, cmd_reg.addr, 10'h0};
      rd_o.valid <= rd_beat;
      rd_o.bank <= cmd == CMD_RD ? bank : bbank_reg;
      rd_o.row <= row_reg[cmd == CMD_RD ? bank : bbank_reg];
      rd_o.col <= cmd == CMD_RD ? col : 10'(bcol_reg + 10'h1) & 10'((1 << COL_W) - 1);
      wr_o.valid <= wr_beat && !dm_reg;
      wr_o.bank <= cmd == CMD_WR ? bank : bbank_reg;
      wr_o.row <= row_reg[cmd == CMD_WR ? bank : bbank_reg];
      wr_o.col <= cmd == CMD_WR ? col : 10'(bcol_reg + 10'h1) & 10'((1 << COL_W) - 1);
      wr_data_o <= dq_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read pipe and mask delay
  logic [2:0] rv_pipe_reg;
  logic [1:0] dm_pipe_reg;
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      rv_pipe_reg <= 3'h0;
      dm_pipe_reg <= 2'h0;
    end
    else
    begin
      rv_pipe_reg <= {rv_pipe_reg[1:0], rd_beat};
      dm_pipe_reg <= {dm_pipe_reg[0], dm_reg};
    end
  end
  logic rd_live;
  assign rd_live = cl3 ? rv_pipe_reg[2] : rv_pipe_reg[1];
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      dq_oe_o <= 1'b0;
      dq_o <= '0;
    end
    else
    begin
      dq_oe_o <= rd_live && !dm_pipe_reg[1];
      dq_o <= rd_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Refresh
  logic [11:0] ref_row_reg;
  logic [31:0] sref_cnt_reg;
  logic sref_tick;
  assign sref_tick = in_sref_reg && sref_cnt_reg == 32'(REF_INT_CYC - 1);
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
      in_sref_reg <= 1'b0;
    // enter on refresh with enable low
    else if (cmd == CMD_SREF)
      in_sref_reg <= 1'b1;
    else if (cmd_reg.clock_enable)
      in_sref_reg <= 1'b0;
  end
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i || !in_sref_reg || sref_tick)
      sref_cnt_reg <= 32'h0;
    else
      sref_cnt_reg <= sref_cnt_reg + 32'h1;
  end
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      ref_row_reg <= 12'h0;
      refresh_o <= 1'b0;
      refresh_row_o <= 12'h0;
    end
    else
    begin
      refresh_o <= cmd == CMD_REF || cmd == CMD_SREF || sref_tick;
      refresh_row_o <= ref_row_reg;
      if (cmd == CMD_REF || cmd == CMD_SREF || sref_tick)
        ref_row_reg <= ref_row_reg + 12'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      bank_open_o <= 4'h0;
      mode_o <= `MODE_RESET;
      self_refresh_o <= 1'b0;
    end
    else
    begin
      bank_open_o <= open_reg;
      mode_o <= mode_reg;
      self_refresh_o <= in_sref_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  inhibit_quiet_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    cmd_reg.chip_select_n |-> cmd == CMD_NOP) else $error("command taken while deselected");
  act_opens_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    cmd == CMD_ACT |=> open_reg[$past(bank)]) else $error("activate did not open bank");
  pre_all_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (cmd == CMD_PRE && cmd_reg.addr[10]) |=> open_reg == 4'h0) else $error("precharge all left bank open");
  mode_load_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (cmd == CMD_MRS && open_reg == 4'h0) |=> mode_reg == $past(cmd_reg.addr)) else $error("mode not loaded");
  wr_mask_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (cmd == CMD_WR && dm_reg) |=> !wr_o.valid) else $error("masked write stored");
  rd_mask_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    dm_reg |-> ##3 !dq_oe_o) else $error("masked read drove data");
  bst_open_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (cmd == CMD_BST && open_reg[bbank_reg]) |=> open_reg[$past(bbank_reg)]) else $error("stop closed row");
  sref_enter_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    cmd == CMD_SREF |=> in_sref_reg) else $error("self refresh not entered");
  ref_count_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    cmd == CMD_REF |=> ref_row_reg == $past(ref_row_reg) + 12'h1) else $error("refresh row not advanced");
  rd_cover_c: cover property (@(posedge core_clk_i) cmd == CMD_RD ##[2:4] dq_oe_o);
  ap_cover_c: cover property (@(posedge core_clk_i) pre_due != 4'h0);
  sref_cover_c: cover property (@(posedge core_clk_i) in_sref_reg ##1 !in_sref_reg);
  mode_wait_c: cover property (@(posedge core_clk_i) mrd_cnt_reg != 3'h0 ##1 mrd_cnt_reg == 3'h0);
endmodule // sdram_cmd_decoder
`default_nettype wire

// File: hw/sdram_cmd_defs.svh
// What this block does
// - Selected with clock enable high, decode strobes into activate, read, write, stop, precharge.
// - Chip deselected registers no command; operations under way continue.
// - No-operation while selected changes nothing and disturbs nothing.
// - Mode load stores A0-A11; only with all banks idle, then wait.
// - Activate opens row in selected bank until that bank is precharged.
// - Column from A0-A9, A0-A8 or A0-A7 by width; bank from bank selects.
// - Address bit ten high with read or write means auto precharge, that command only.
// - Read mask acts two clocks later: high floats data, low drives data.
// - Write mask acts at once: low stores data, high leaves location unwritten.
// - Precharge closes selected bank, or all banks when flag high; ready after period.
// - Auto precharge closes bank when burst completes, unless a read, write or stop comes right after the last beat; not for full-page bursts.
// - Burst stop truncates latest read or write burst and leaves row open.
// - Auto refresh uses internal row counter and ignores address inputs.
// - Refresh code with clock enable low enters self refresh; other inputs ignored.
// - Self refresh refreshes internally; controller stays at least row active minimum.
// - Refresh code is auto refresh with enable high; other commands need enable high.
// - Read latency selectable as two or three clocks through mode register.
// - Write burst mode bit one makes writes single-location except with full-page length; reads keep burst length.
`ifndef SDRAM_CMD_DEFS_SVH
`define SDRAM_CMD_DEFS_SVH
`define CLK_PERIOD_NS 50
`define PRECHARGE_PERIOD_NS 20
`define PRECHARGE_CYC ((`PRECHARGE_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MODE_LOAD_WAIT_CYC 2
`define SELF_REFRESH_INT_NS 15625
`define SELF_REFRESH_INT_CYC (`SELF_REFRESH_INT_NS / `CLK_PERIOD_NS)
`define MODE_RESET 12'h0_022
`define MODE_BL_LSB 0
`define MODE_BT_BIT 3
`define MODE_CL_LSB 4
`define MODE_WB_BIT 9
`endif

// File: hw/sdram_cmd_pkg.sv
package sdram_cmd_pkg;
  typedef enum {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_BST, CMD_PRE, CMD_REF, CMD_MRS, CMD_SREF} cmd_t;
  typedef struct packed {
    logic chip_select_n;
    logic row_strobe_n;
    logic column_strobe_n;
    logic write_enable_n;
    logic clock_enable;
    logic bank_select_bit1;
    logic bank_select_bit0;
    logic [11:0] addr;
  } cmd_bus_t;
  typedef struct packed {
    logic valid;
    logic [1:0] bank;
    logic [11:0] row;
    logic [9:0] col;
  } array_req_t;
endpackage

// File: sim/sdram_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdram_ctrl_model
  import sdram_cmd_pkg::*;
(
  // Clock
  input wire logic core_clk_i,
  // Command pins
  output var sdram_cmd_pkg::cmd_bus_t cmd_o,
  output var logic data_mask_o
);
  initial
  begin
    cmd_o = {1'b1, 3'b111, 1'b1, 2'b00, 12'h000};
    data_mask_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // encoded command, one cycle
  task automatic issue(input logic [2:0] rcw, input logic [1:0] ba, input logic [11:0] a,
    input logic cke, input logic csn, input logic dm, input int gap);
    @(posedge core_clk_i);
    cmd_o <= {csn, rcw, cke, ba, a};
    data_mask_o <= dm;
    @(posedge core_clk_i);
    cmd_o <= {1'b0, 3'b111, cke, ~ba, ~a};
    repeat (gap) @(posedge core_clk_i);
  endtask
endmodule // sdram_ctrl_model
`default_nettype wire

// File: sim/sdram_cmd_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sdram_cmd_decoder_tb_top;
  import sdram_cmd_pkg::*;
  localparam int COL_W = 8;
  localparam int DQ_W = 16;
  localparam logic [2:0] ACT = 3'b011, RD = 3'b101, WR = 3'b100, BST = 3'b110;
  localparam logic [2:0] PRE = 3'b010, REF = 3'b001, MRS = 3'b000, NOP = 3'b111;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  cmd_bus_t cmd;
  logic dm;
  logic [DQ_W-1:0] dq_i = '0;
  logic [DQ_W-1:0] rd_data = '0;
  logic [DQ_W-1:0] dq_o;
  logic [DQ_W-1:0] wr_data;
  logic dq_oe;
  array_req_t act_o, rd_o, wr_o, last_act, last_rd;
  logic [11:0] ref_row, mode;
  logic ref_p, sref;
  logic [3:0] bank_open;
  logic [15:0] lfsr_state = 16'h4137;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_act = 0, n_wr = 0, n_ref = 0, n_oe = 0;
  int cyc = 0, rd_cyc = 0, oe_cyc = 0;
  logic rd_prev = 1'b0, oe_prev = 1'b0;
  logic [DQ_W-1:0] dq_h1 = '0, dq_h2 = '0, dq_h3 = '0, rd_h1 = '0;
  array_req_t last_wr;
  always #25 core_clk_i = ~core_clk_i;
  sdram_ctrl_model ctl (.core_clk_i(core_clk_i), .cmd_o(cmd), .data_mask_o(dm));
  sdram_cmd_decoder #(.DQ_W(DQ_W), .COL_W(COL_W), .REF_INT_CYC(8)) dut (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .cmd_i(cmd), .data_mask_i(dm), .dq_i(dq_i),
    .dq_o(dq_o), .dq_oe_o(dq_oe), .act_o(act_o), .rd_o(rd_o), .wr_o(wr_o), .wr_data_o(wr_data),
    .rd_data_i(rd_data), .refresh_row_o(ref_row), .refresh_o(ref_p), .bank_open_o(bank_open),
    .mode_o(mode), .self_refresh_o(sref));
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] next_rand();
    lfsr_state = {lfsr_state[14:0], lfsr_state[15] ^ lfsr_state[13] ^ lfsr_state[12] ^ lfsr_state[10]};
    return lfsr_state;
  endfunction
  function automatic logic [9:0] col_of(input logic [11:0] a);
    return {{(10-COL_W){1'b0}}, a[COL_W-1:0]};
  endfunction
  always @(posedge core_clk_i)
  begin
    dq_i <= next_rand();
    rd_data <= ~dq_i;
    // Pin history for data compares
    dq_h1 <= dq_i;
    dq_h2 <= dq_h1;
    dq_h3 <= dq_h2;
    rd_h1 <= rd_data;
    cyc <= cyc + 1;
  end
  // Pulse counters, sampled mid-cycle
  always @(negedge core_clk_i)
  begin
    if (act_o.valid === 1'b1)
    begin
      n_act++;
      last_act = act_o;
    end
    if (rd_o.valid === 1'b1 && !rd_prev)
      rd_cyc = cyc;
    if (rd_o.valid === 1'b1)
      last_rd = rd_o;
    if (wr_o.valid === 1'b1)
    begin
      n_wr++;
      last_wr = wr_o;
      check("wr data", wr_data, dq_h3);
    end
    if (ref_p === 1'b1)
      n_ref++;
    if (dq_oe === 1'b1 && !oe_prev)
      oe_cyc = cyc;
    if (dq_oe === 1'b1)
    begin
      n_oe++;
      check("rd data", dq_o, rd_h1);
    end
    rd_prev = rd_o.valid === 1'b1;
    oe_prev = dq_oe === 1'b1;
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (4000) @(posedge core_clk_i);
    n_mismatch++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    logic [15:0] r;
    logic [11:0] row;
    logic [11:0] a;
    logic [11:0] r0;
    int c0;
    int b;
    int c1;
    repeat (3) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    @(posedge core_clk_i);
    check("bank_open", bank_open, 4'h0);
    check("mode", mode, 12'h022);
    check("self_refresh", sref, 1'b0);
    c0 = n_act;
    ctl.issue(ACT, 2'd1, 12'h5A5, 1'b1, 1'b1, 1'b0, 6);
    ctl.issue(NOP, 2'd1, 12'h5A5, 1'b1, 1'b0, 1'b0, 6);
    check("deselect/nop act", n_act - c0, 0);
    check("deselect/nop bank", bank_open, 4'h0);
    $display("idle test done");
    for (b = 0; b < 4; b++)
    begin
      r = next_rand();
      row = r[11:0];
      ctl.issue(ACT, b[1:0], row, 1'b1, 1'b0, 1'b0, 4);
      check("act row", last_act.row, row);
      check("act bank", last_act.bank, b[1:0]);
      check("open bank", bank_open[b], 1'b1);
    end
    for (b = 0; b < 2; b++)
    begin
      r = next_rand();
      a = {2'b00, 1'b0, r[8:0]};
      c0 = n_oe;
      ctl.issue(RD, 2'd0, a, 1'b1, 1'b0, b[0], 12);
      check("rd col", last_rd.col, col_of(a + 12'h003));
      check("rd beats", n_oe - c0, b[0] ? 0 : 4);
      c0 = n_wr;
      ctl.issue(WR, 2'd0, a, 1'b1, 1'b0, b[0], 8);
      check("wr beats", n_wr - c0, b[0] ? 0 : 4);
    end
    c0 = n_oe;
    ctl.issue(RD, 2'd0, 12'h020, 1'b1, 1'b0, 1'b0, 0);
    ctl.issue(NOP, 2'd0, 12'h000, 1'b1, 1'b0, 1'b1, 12);
    check("mask mid", n_oe - c0, 2);
    check("cl2 latency", oe_cyc - rd_cyc, 2);
    check("row kept", bank_open[0], 1'b1);
    ctl.issue(RD, 2'd1, 12'h407, 1'b1, 1'b0, 1'b0, 14);
    check("auto close", bank_open, 4'hD);
    c0 = n_oe;
    ctl.issue(RD, 2'd2, 12'h010, 1'b1, 1'b0, 1'b0, 0);
    ctl.issue(BST, 2'd2, 12'h000, 1'b1, 1'b0, 1'b0, 12);
    check("stop cut", (n_oe - c0) < 4, 1'b1);
    check("stop open", bank_open[2], 1'b1);
    ctl.issue(PRE, 2'd3, 12'h000, 1'b1, 1'b0, 1'b0, 4);
    check("single close", bank_open, 4'h5);
    ctl.issue(MRS, 2'd0, 12'h232, 1'b1, 1'b0, 1'b0, 4);
    check("mode refused", mode, 12'h022);
    r = next_rand();
    ctl.issue(PRE, r[1:0], 12'h400, 1'b1, 1'b0, 1'b0, 4);
    check("all close", bank_open, 4'h0);
    $display("bank test done");
    ctl.issue(MRS, 2'd0, 12'h232, 1'b1, 1'b0, 1'b0, 4);
    check("mode load", mode, 12'h232);
    ctl.issue(ACT, 2'd3, 12'h0F0, 1'b1, 1'b0, 1'b0, 4);
    c0 = n_wr;
    ctl.issue(WR, 2'd3, 12'h004, 1'b1, 1'b0, 1'b0, 8);
    check("single write", n_wr - c0, 1);
    check("wr bank", last_wr.bank, 2'd3);
    check("wr row", last_wr.row, 12'h0F0);
    check("wr col", last_wr.col, col_of(12'h004));
    c0 = n_oe;
    ctl.issue(RD, 2'd3, 12'h404, 1'b1, 1'b0, 1'b0, 14);
    check("cl3 beats", n_oe - c0, 4);
    check("cl3 latency", oe_cyc - rd_cyc, 3);
    check("cl3 close", bank_open, 4'h0);
    $display("mode test done");
    c0 = n_ref;
    ctl.issue(REF, 2'd0, 12'h000, 1'b1, 1'b0, 1'b0, 4);
    r0 = ref_row;
    ctl.issue(REF, 2'd3, 12'hFFF, 1'b1, 1'b0, 1'b0, 4);
    check("auto refresh", n_ref - c0, 2);
    check("refresh row", ref_row, r0 + 12'h001);
    c0 = n_act;
    ctl.issue(ACT, 2'd0, 12'h111, 1'b0, 1'b0, 1'b0, 2);
    ctl.issue(NOP, 2'd0, 12'h000, 1'b1, 1'b0, 1'b0, 2);
    check("act cke low", n_act - c0, 0);
    ctl.issue(REF, 2'd0, 12'h000, 1'b0, 1'b0, 1'b0, 4);
    check("sr entry", sref, 1'b1);
    c0 = n_ref;
    c1 = n_act;
    ctl.issue(ACT, 2'd1, 12'h222, 1'b0, 1'b0, 1'b0, 20);
    check("sr ignore", n_act - c1, 0);
    check("sr no act", bank_open, 4'h0);
    check("sr internal", (n_ref - c0) >= 2, 1'b1);
    ctl.issue(NOP, 2'd0, 12'h000, 1'b1, 1'b0, 1'b0, 4);
    check("sr exit", sref, 1'b0);
    c0 = n_ref;
    ctl.issue(REF, 2'd0, 12'h000, 1'b1, 1'b0, 1'b0, 4);
    check("refresh resumed", n_ref - c0, 1);
    $display("refresh test done");
    print_verdict();
  end
endmodule // sdram_cmd_decoder_tb_top
`default_nettype wire
